/* File: sfb_asserts.sv */
// checks on the link between host and flash front end
`default_nettype none
module sfb_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic hold_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic quad_mode,
  input wire logic cmd_valid,
  input wire logic write_enable_latch,
  input wire logic paused
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_float_deselect: assert property (cs_n [*5] |-> !miso_oe)
    else $error("driven while deselected");
  a_float_hold: assert property ($fell(hold_n) && !quad_mode |-> ##[1:4] !miso_oe)
    else $error("driven after pause");
  a_hold_keeps: assert property (!hold_n && !quad_mode && !miso_oe |=> !miso_oe)
    else $error("driven in pause");
  a_launch_fall: assert property ($rose(sclk) |-> ##1 $stable(miso) [*8])
    else $error("output moved after rise");
  a_exec_deselected: assert property (cmd_valid |-> cs_n && $past(cs_n))
    else $error("executed while selected");
  a_exec_latch: assert property (cmd_valid |-> $past(write_enable_latch))
    else $error("executed without latch");
  a_latch_clear: assert property (cmd_valid |-> ##[1:2] !write_enable_latch)
    else $error("latch kept");
  a_pause_start: assert property ($rose(paused) |-> !hold_n && !cs_n && !quad_mode)
    else $error("pause without cause");
  a_pause_end: assert property ((hold_n && !sclk) [*6] |-> !paused)
    else $error("pause not ended");
  a_pause_reset: assert property (cs_n [*5] |-> !paused)
    else $error("pause kept deselected");
  c_pause: cover property ($rose(paused));
  c_exec: cover property (cmd_valid);
  c_drive: cover property ($rose(miso_oe));
  c_quad: cover property ($fell(hold_n) && quad_mode);
endmodule
`default_nettype wire

/* File: sfb_dev.sv */
// flash side of the serial link: framing, decode, hold and array map
`default_nettype none
module sfb_dev (
  input  wire logic        clk,
  input  wire logic        rst_n,
  sfb_if.dev               link,
  input  wire logic        quad_mode,
  input  wire logic        busy,
  input  wire logic [7:0]  rd_data,
  output logic             rd_req,
  output logic [23:0]      rd_addr,
  output logic             wr_valid,
  output logic [7:0]       wr_data,
  output logic             cmd_valid,
  output logic             cmd_reject,
  output logic [7:0]       cmd_op,
  output logic [23:0]      cmd_addr,
  output logic [3:0]       cmd_block,
  output logic [4:0]       cmd_half,
  output logic [7:0]       cmd_sector,
  output logic             write_enable_latch,
  output logic             paused
);
  typedef struct packed {
    logic [1:0]          cs_sy;
    logic [1:0]          sck_sy;
    logic [1:0]          mosi_sy;
    logic [1:0]          hold_sy;
    logic                sck_prev;
    sfb_pkg::sfb_dev_st_t st;
    logic [2:0]          bit_cnt;
    logic [1:0]          byte_cnt;
    logic [7:0]          sh;
    logic [7:0]          op;
    logic [23:0]         addr;
    logic                hold;
    logic                write_enable_latch;
    logic                drv;
    logic [6:0]          out_sh;
    logic                miso;
    logic                miso_oe;
    logic                rd_req;
    logic                wr_valid;
    logic [7:0]          wr_data;
    logic                cmd_valid;
    logic                cmd_reject;
    logic [7:0]          cmd_op;
    logic [23:0]         cmd_addr;
  } sfb_dev_state_t;

  sfb_dev_state_t r;
  sfb_dev_state_t n;
  logic           cs;
  logic           sck;
  logic           mosi;
  logic           hold_n;
  logic           rise;
  logic           fall;
  logic           last;
  logic           boundary;
  logic [7:0]     sh_new;
  logic [23:0]    addr_new;
  logic [7:0]     out_byte;
  logic [7:0]     status_byte;

  assign cs     = r.cs_sy[1];
  assign sck    = r.sck_sy[1];
  assign mosi   = r.mosi_sy[1];
  assign hold_n = r.hold_sy[1];

  always_comb
  begin
    n = r;
    n.cs_sy    = {r.cs_sy[0], link.cs_n};
    n.sck_sy   = {r.sck_sy[0], link.sclk};
    n.mosi_sy  = {r.mosi_sy[0], link.mosi};
    n.hold_sy  = {r.hold_sy[0], link.hold_n};
    n.sck_prev = sck;
    n.rd_req     = 1'b0;
    n.wr_valid   = 1'b0;
    n.cmd_valid  = 1'b0;
    n.cmd_reject = 1'b0;
    rise     = ~cs & sck & ~r.sck_prev & ~r.hold;
    fall     = ~cs & ~sck & r.sck_prev & ~r.hold;
    last     = (r.bit_cnt == sfb_pkg::BIT_LAST);
    boundary = (r.bit_cnt == sfb_pkg::BIT_FIRST);
    sh_new   = {r.sh[6:0], mosi};
    addr_new = {r.addr[15:0], sh_new};
    status_byte = 8'h00;
    status_byte[sfb_pkg::STAT_BUSY] = busy;
    status_byte[sfb_pkg::STAT_WEL]  = r.write_enable_latch;
    out_byte = (r.op == sfb_pkg::STATUS_READ_CMD) ? status_byte : rd_data;

    if (quad_mode | cs)
    begin
      n.hold = 1'b0;
    end
    else if (r.hold)
    begin
      n.hold = ~(hold_n & ~sck);
    end
    else
    begin
      n.hold = ~hold_n & ~sck;
    end

    if (cs)
    begin
      if (boundary && (r.st == sfb_pkg::DEV_WAIT_END || r.st == sfb_pkg::DEV_DATA_IN))
      begin
        if (r.op == sfb_pkg::WRITE_ENABLE_CMD)
        begin
          n.write_enable_latch = 1'b1;
        end
        else if (r.op == sfb_pkg::WRITE_DISABLE_CMD)
        begin
          n.write_enable_latch = 1'b0;
        end
        else
        begin
          n.write_enable_latch       = 1'b0;
          n.cmd_valid = 1'b1;
          n.cmd_op    = r.op;
          n.cmd_addr  = r.addr & sfb_pkg::ARRAY_LAST;
        end
      end
      else if ((r.st == sfb_pkg::DEV_WAIT_END || r.st == sfb_pkg::DEV_DATA_IN ||
                r.st == sfb_pkg::DEV_ADDR) && !sfb_pkg::needs_addr(r.op) == 1'b0
               || r.st == sfb_pkg::DEV_WAIT_END || r.st == sfb_pkg::DEV_DATA_IN)
      begin
        n.cmd_reject = ~sfb_pkg::is_array_read(r.op);
      end
      n.st      = sfb_pkg::DEV_IDLE;
      n.bit_cnt = sfb_pkg::BIT_FIRST;
      n.drv     = 1'b0;
    end
    else if (r.st == sfb_pkg::DEV_IDLE)
    begin
      n.st       = sfb_pkg::DEV_OPCODE;
      n.bit_cnt  = sfb_pkg::BIT_FIRST;
      n.byte_cnt = 2'h0;
    end
    else if (rise)
    begin
      n.sh      = sh_new;
      n.bit_cnt = r.bit_cnt + 3'h1;
      if (last)
      begin
        unique case (r.st)
          sfb_pkg::DEV_OPCODE:
          begin
            n.op = sh_new;
            if (!sfb_pkg::is_known(sh_new))
            begin
              n.st = sfb_pkg::DEV_STANDBY;
            end
            else if ((sfb_pkg::is_change(sh_new) && (!r.write_enable_latch || busy)) ||
                     (sfb_pkg::is_array_read(sh_new) && busy))
            begin
              n.st         = sfb_pkg::DEV_STANDBY;
              n.cmd_reject = 1'b1;
            end
            else if (sfb_pkg::needs_addr(sh_new))
            begin
              n.st = sfb_pkg::DEV_ADDR;
            end
            else if (sh_new == sfb_pkg::STATUS_READ_CMD || sh_new == sfb_pkg::CONFIG_READ_CMD)
            begin
              n.st     = sfb_pkg::DEV_DATA_OUT;
              n.rd_req = 1'b1;
            end
            else if (sh_new == sfb_pkg::STATUS_WRITE_CMD)
            begin
              n.st = sfb_pkg::DEV_DATA_IN;
            end
            else
            begin
              n.st = sfb_pkg::DEV_WAIT_END;
            end
          end
          sfb_pkg::DEV_ADDR:
          begin
            n.addr     = addr_new;
            n.byte_cnt = r.byte_cnt + 2'h1;
            if (r.byte_cnt == sfb_pkg::ADDR_BYTE_LAST)
            begin
              if (sfb_pkg::has_dummy(r.op))
              begin
                n.st = sfb_pkg::DEV_DUMMY;
              end
              else if (sfb_pkg::is_array_read(r.op))
              begin
                n.st     = sfb_pkg::DEV_DATA_OUT;
                n.rd_req = 1'b1;
              end
              else if (r.op == sfb_pkg::PAGE_PROGRAM_CMD)
              begin
                n.st = sfb_pkg::DEV_DATA_IN;
              end
              else
              begin
                n.st = sfb_pkg::DEV_WAIT_END;
              end
            end
          end
          sfb_pkg::DEV_DUMMY:
          begin
            n.st     = sfb_pkg::DEV_DATA_OUT;
            n.rd_req = 1'b1;
          end
          sfb_pkg::DEV_DATA_IN:
          begin
            n.wr_valid = 1'b1;
            n.wr_data  = sh_new;
          end
          default:
          begin
            n.st = r.st;
          end
        endcase
      end
    end
    else if (fall && r.st == sfb_pkg::DEV_DATA_OUT)
    begin
      n.drv = 1'b1;
      if (boundary)
      begin
        n.miso   = out_byte[7];
        n.out_sh = out_byte[6:0];
        n.addr   = (r.addr + sfb_pkg::ADDR_ONE) & sfb_pkg::ARRAY_LAST;
        n.rd_req = 1'b1;
      end
      else
      begin
        n.miso   = r.out_sh[6];
        n.out_sh = {r.out_sh[5:0], 1'b0};
      end
    end
    n.miso_oe = n.drv & ~cs & (hold_n | quad_mode);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r         <= '0;
      r.cs_sy   <= 2'h3;
      r.hold_sy <= 2'h3;
    end
    else
    begin
      r <= n;
    end
  end

  assign link.miso    = r.miso;
  assign link.miso_oe = r.miso_oe;
  assign rd_req       = r.rd_req;
  assign rd_addr      = r.addr;
  assign wr_valid     = r.wr_valid;
  assign wr_data      = r.wr_data;
  assign cmd_valid    = r.cmd_valid;
  assign cmd_reject   = r.cmd_reject;
  assign cmd_op       = r.cmd_op;
  assign cmd_addr     = r.cmd_addr;
  assign cmd_block    = r.cmd_addr[sfb_pkg::ARRAY_MSB:sfb_pkg::BLOCK_LSB];
  assign cmd_half     = r.cmd_addr[sfb_pkg::ARRAY_MSB:sfb_pkg::HALF_LSB];
  assign cmd_sector   = r.cmd_addr[sfb_pkg::ARRAY_MSB:sfb_pkg::SECTOR_LSB];
  assign write_enable_latch          = r.write_enable_latch;
  assign paused       = r.hold;
endmodule
`default_nettype wire

/* File: sfb_fifo.sv */
// byte fifo with valid and ready on both sides
`default_nettype none
module sfb_fifo #(
  parameter int W     = sfb_pkg::FIFO_W,
  parameter int DEPTH = sfb_pkg::FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic [W-1:0]      m_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sfb_fifo_state_t;
  sfb_fifo_state_t r;
  sfb_fifo_state_t n;
  logic [W-1:0]    mem [DEPTH];
  logic            push;
  logic            pop;

  assign s_ready = (r.cnt != (AW+1)'(DEPTH));
  assign m_valid = (r.cnt != '0);
  assign m_data  = mem[r.rp];
  assign push    = s_valid & s_ready;
  assign pop     = m_valid & m_ready;

  always_comb
  begin
    n = r;
    if (push)
    begin
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
    end
    if (pop)
    begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[r.wp] <= s_data;
    end
  end
endmodule
`default_nettype wire

/* File: sfb_host.sv */
// host side of the serial link: clock divider, framing, hold, tx fifo
`default_nettype none
module sfb_host #(
  parameter int HALF_CYC = sfb_pkg::SCK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  sfb_if.host              link,
  input  wire logic        cpol,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  input  wire logic        start,
  input  wire logic [7:0]  frame_len,
  input  wire logic        auto_write_enable_cmd,
  input  wire logic        hold_req,
  output logic             busy,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             done
);
  typedef struct packed {
    sfb_pkg::sfb_hst_st_t st;
    logic [1:0]          miso_sy;
    logic [7:0]          div;
    logic                sck;
    logic                cs_n;
    logic                mosi;
    logic                hold_n;
    logic [2:0]          bit_cnt;
    logic [7:0]          len;
    logic [7:0]          left;
    logic [7:0]          sh;
    logic                write_enable_cmd_pend;
    logic                busy;
    logic                rx_valid;
    logic [7:0]          rx_data;
    logic                done;
  } sfb_hst_state_t;

  sfb_hst_state_t r;
  sfb_hst_state_t n;
  logic           tick;
  logic           q_valid;
  logic           q_pop;
  logic [7:0]     q_data;

  sfb_fifo #(.W(sfb_pkg::FIFO_W), .DEPTH(sfb_pkg::FIFO_DEPTH)) u_txq (
    .clk     (clk),
    .rst_n   (rst_n),
    .s_valid (tx_valid),
    .s_ready (tx_ready),
    .s_data  (tx_data),
    .m_valid (q_valid),
    .m_ready (q_pop),
    .m_data  (q_data)
  );

  assign q_pop = (r.st == sfb_pkg::HST_LOAD) & ~r.write_enable_cmd_pend & q_valid;
  assign tick  = (r.div == 8'h00);

  always_comb
  begin
    n = r;
    n.miso_sy  = {r.miso_sy[0], link.miso_line};
    n.rx_valid = 1'b0;
    n.done     = 1'b0;
    n.div      = tick ? 8'(HALF_CYC - 1) : r.div - 8'h01;
    unique case (r.st)
      sfb_pkg::HST_IDLE:
      begin
        n.sck = cpol;
        n.div = 8'(HALF_CYC - 1);
        if (start && frame_len != 8'h00)
        begin
          n.st   = sfb_pkg::HST_SETUP;
          n.len  = frame_len;
          n.busy = 1'b1;
          n.write_enable_cmd_pend = auto_write_enable_cmd & q_valid & sfb_pkg::is_change(q_data);
        end
      end
      sfb_pkg::HST_SETUP:
      begin
        n.cs_n = 1'b0;
        n.left = r.write_enable_cmd_pend ? 8'h01 : r.len;
        if (tick)
        begin
          n.st = sfb_pkg::HST_LOAD;
        end
      end
      sfb_pkg::HST_LOAD:
      begin
        n.div = 8'(HALF_CYC - 1);
        if (r.write_enable_cmd_pend || q_valid)
        begin
          n.sh      = r.write_enable_cmd_pend ? sfb_pkg::WRITE_ENABLE_CMD : q_data;
          n.bit_cnt = sfb_pkg::BIT_FIRST;
          n.st      = sfb_pkg::HST_LOW;
          n.sck     = 1'b0;
          n.mosi    = r.write_enable_cmd_pend ? sfb_pkg::WRITE_ENABLE_CMD[7] : q_data[7];
        end
      end
      sfb_pkg::HST_LOW:
      begin
        if (tick)
        begin
          // pause asserted only with clock low
          if (hold_req)
          begin
            n.hold_n = 1'b0;
          end
          else if (!r.hold_n)
          begin
            n.hold_n = 1'b1;
          end
          else
          begin
            n.st  = sfb_pkg::HST_HIGH;
            n.sck = 1'b1;
            n.sh  = {r.sh[6:0], r.miso_sy[1]};
          end
        end
      end
      sfb_pkg::HST_HIGH:
      begin
        if (tick)
        begin
          n.bit_cnt = r.bit_cnt + 3'h1;
          if (r.bit_cnt == sfb_pkg::BIT_LAST)
          begin
            n.rx_valid = ~r.write_enable_cmd_pend;
            n.rx_data  = r.sh;
            n.left     = r.left - 8'h01;
            n.st       = (r.left == 8'h01) ? sfb_pkg::HST_END : sfb_pkg::HST_LOAD;
            n.sck      = (r.left == 8'h01) ? cpol : 1'b0;
          end
          else
          begin
            n.st   = sfb_pkg::HST_LOW;
            n.sck  = 1'b0;
            n.mosi = r.sh[7];
          end
        end
      end
      sfb_pkg::HST_END:
      begin
        if (tick)
        begin
          n.cs_n = 1'b1;
          n.st   = sfb_pkg::HST_GAP;
        end
      end
      sfb_pkg::HST_GAP:
      begin
        if (tick)
        begin
          n.write_enable_cmd_pend = 1'b0;
          n.st        = r.write_enable_cmd_pend ? sfb_pkg::HST_SETUP : sfb_pkg::HST_IDLE;
          n.busy      = r.write_enable_cmd_pend;
          n.done      = ~r.write_enable_cmd_pend;
        end
      end
      default:
      begin
        n.st = sfb_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r        <= '0;
      r.cs_n   <= 1'b1;
      r.hold_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign link.cs_n   = r.cs_n;
  assign link.sclk   = r.sck;
  assign link.mosi   = r.mosi;
  assign link.hold_n = r.hold_n;
  assign busy        = r.busy;
  assign rx_valid    = r.rx_valid;
  assign rx_data     = r.rx_data;
  assign done        = r.done;
endmodule
`default_nettype wire

/* File: sfb_if.sv */
// serial link between host and flash front end
`default_nettype none
interface sfb_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic hold_n;
  logic miso;
  logic miso_oe;
  logic miso_line;
  // floated output reads as the pull-up level
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev (input cs_n, input sclk, input mosi, input hold_n, output miso, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, output hold_n, input miso_line);
endinterface
`default_nettype wire

/* File: sfb_pkg.sv */
// shared constants, opcodes and state codes of the serial flash front end
`default_nettype none
package sfb_pkg;
  // array map: 1 MB, 64 KB blocks, 32 KB halves, 4 KB sectors
  localparam int              ADDR_W      = 24;
  localparam logic [23:0]     ARRAY_LAST  = 24'h0fffff;
  localparam int              BLOCK_LSB   = 16;
  localparam int              HALF_LSB    = 15;
  localparam int              SECTOR_LSB  = 12;
  localparam int              ARRAY_MSB   = 19;
  localparam logic [23:0]     ADDR_ONE    = 24'h000001;
  // opcodes
  localparam logic [7:0] WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD     = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
  localparam logic [7:0] CONFIG_READ_CMD       = 8'h15;
  localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD        = 8'h03;
  localparam logic [7:0] FAST_ARRAY_READ_CMD   = 8'h0b;
  localparam logic [7:0] PARAM_TABLE_READ_CMD  = 8'h5a;
  localparam logic [7:0] SECTOR_ERASE_CMD      = 8'h20;
  localparam logic [7:0] HALF_BLOCK_ERASE_CMD  = 8'h52;
  localparam logic [7:0] BLOCK_ERASE_CMD       = 8'hd8;
  localparam logic [7:0] PAGE_PROGRAM_CMD      = 8'h02;
  localparam logic [7:0] CHIP_ERASE_CMD        = 8'h60;
  localparam logic [7:0] CHIP_ERASE_ALT_CMD    = 8'hc7;
  // framing counts and status bit positions
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [2:0] BIT_FIRST       = 3'h0;
  localparam logic [1:0] ADDR_BYTE_LAST  = 2'h2;
  localparam int         STAT_BUSY       = 0;
  localparam int         STAT_WEL        = 1;
  // link clock made by the host: half period in ns, then in cycles
  localparam int CLK_NS       = 8;
  localparam int SCK_HALF_NS  = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS / CLK_NS < 1) ? 1 : SCK_HALF_NS / CLK_NS;
  localparam int FIFO_W       = 8;
  localparam int FIFO_DEPTH   = 16;

  typedef enum logic [2:0] {
    DEV_IDLE     = 3'b000,
    DEV_OPCODE   = 3'b001,
    DEV_ADDR     = 3'b010,
    DEV_DUMMY    = 3'b011,
    DEV_DATA_IN  = 3'b100,
    DEV_DATA_OUT = 3'b101,
    DEV_WAIT_END = 3'b110,
    DEV_STANDBY  = 3'b111
  } sfb_dev_st_t;

  typedef enum logic [2:0] {
    HST_IDLE  = 3'b000,
    HST_SETUP = 3'b001,
    HST_LOAD  = 3'b010,
    HST_LOW   = 3'b011,
    HST_HIGH  = 3'b100,
    HST_END   = 3'b101,
    HST_GAP   = 3'b110
  } sfb_hst_st_t;

  function automatic logic is_change(input logic [7:0] op);
    is_change = (op == STATUS_WRITE_CMD) || (op == SECTOR_ERASE_CMD) ||
                (op == HALF_BLOCK_ERASE_CMD) || (op == BLOCK_ERASE_CMD) ||
                (op == PAGE_PROGRAM_CMD) || (op == CHIP_ERASE_CMD) ||
                (op == CHIP_ERASE_ALT_CMD);
  endfunction

  function automatic logic is_array_read(input logic [7:0] op);
    is_array_read = (op == ARRAY_READ_CMD) || (op == FAST_ARRAY_READ_CMD);
  endfunction

  function automatic logic needs_addr(input logic [7:0] op);
    needs_addr = is_array_read(op) || (op == PARAM_TABLE_READ_CMD) ||
                 (op == SECTOR_ERASE_CMD) || (op == HALF_BLOCK_ERASE_CMD) ||
                 (op == BLOCK_ERASE_CMD) || (op == PAGE_PROGRAM_CMD);
  endfunction

  function automatic logic has_dummy(input logic [7:0] op);
    has_dummy = (op == FAST_ARRAY_READ_CMD) || (op == PARAM_TABLE_READ_CMD);
  endfunction

  function automatic logic is_known(input logic [7:0] op);
    is_known = is_change(op) || needs_addr(op) || (op == WRITE_ENABLE_CMD) ||
               (op == WRITE_DISABLE_CMD) || (op == STATUS_READ_CMD) ||
               (op == CONFIG_READ_CMD);
  endfunction
endpackage
`default_nettype wire

/* File: test_serial_flash_bus_front_end.sv */
// self-checking bench: host and flash front end joined over the link
`default_nettype none
module test_serial_flash_bus_front_end;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, cpol, tx_valid, tx_ready, start, auto_write_enable_cmd, hold_req;
  logic        hbusy, rx_valid, done, quad_mode, dev_busy, rd_req;
  logic        cmd_valid, cmd_reject, write_enable_latch, paused, cv2, cr2, wel2;
  logic [7:0]  tx_data, frame_len, rx_data, rd_data, cmd_op, cmd_sector;
  logic [23:0] rd_addr, cmd_addr, a, m;
  logic [3:0]  cmd_block;
  logic [4:0]  cmd_half;
  logic [48:0] c;
  logic [7:0]  rxq[$];
  logic [7:0]  ops[4] = '{8'h20, 8'h52, 8'hd8, 8'h20};
  logic [23:0] adr[4] = '{24'h0fffff, 24'h07f000, 24'h090000, 24'h1ff000};
  int          mismatches = 0, n_checks = 0, nv = 0, nr = 0, nv2 = 0, nr2 = 0, cyc = 0;
  sfb_if lnk();
  sfb_if lnk2();
  sfb_host #(.HALF_CYC(10)) sfb_host_i (.clk, .rst_n, .link(lnk.host), .cpol, .tx_valid,
    .tx_ready, .tx_data, .start, .frame_len, .auto_write_enable_cmd, .hold_req, .busy(hbusy), .rx_valid,
    .rx_data, .done);
  sfb_dev sfb_dev_i (.clk, .rst_n, .link(lnk.dev), .quad_mode, .busy(dev_busy), .rd_data,
    .rd_req, .rd_addr, .wr_valid(), .wr_data(), .cmd_valid, .cmd_reject, .cmd_op, .cmd_addr,
    .cmd_block, .cmd_half, .cmd_sector, .write_enable_latch, .paused);
  // second front end driven bit by bit to break the framing on purpose
  sfb_dev sfb_dev_i2 (.clk, .rst_n, .link(lnk2.dev), .quad_mode(1'b0), .busy(1'b0),
    .rd_data(8'h00), .rd_req(), .rd_addr(), .wr_valid(), .wr_data(), .cmd_valid(cv2),
    .cmd_reject(cr2), .cmd_op(), .cmd_addr(), .cmd_block(), .cmd_half(), .cmd_sector(),
    .write_enable_latch(wel2), .paused());
  sfb_asserts sfb_asserts_i (.clk, .rst_n, .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .hold_n(lnk.hold_n), .miso(lnk.miso), .miso_oe(lnk.miso_oe), .quad_mode, .cmd_valid,
    .write_enable_latch, .paused);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // array byte returned for an address, wrapping at the top of the array
  function automatic logic [7:0] ex(input logic [23:0] b, input int k);
    logic [23:0] t;
    t = (b + 24'(k)) & sfb_pkg::ARRAY_LAST;
    return t[7:0] ^ 8'h5a;
  endfunction

  always @(posedge clk)
  begin
    cyc++;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rd_req === 1'b1) rd_data <= rd_addr[7:0] ^ 8'h5a;
    if (cmd_valid === 1'b1)
    begin
      nv++;
      c = {cmd_op, cmd_addr, cmd_block, cmd_half, cmd_sector};
    end
    nr += (cmd_reject === 1'b1);
    nv2 += (cv2 === 1'b1);
    nr2 += (cr2 === 1'b1);
    if (cyc == 40000)
    begin
      mismatches++;
      results();
    end
  end

  task chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task push(input logic [127:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      tx_data <= v[8*i +: 8];
      tx_valid <= 1'b1;
      do @(posedge clk); while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
  endtask

  task go(input int n);
    rxq.delete();
    start <= 1'b1;
    frame_len <= 8'(n);
    @(posedge clk);
    start <= 1'b0;
    for (int k = 0; k < 4000 && done !== 1'b1; k++) @(posedge clk);
    repeat (12) @(posedge clk);
  endtask

  task fr(input logic [127:0] v, input int n);
    push(v, n);
    go(n);
  endtask

  // readout with a pause in the address phase
  task rdp(input logic [23:0] b, input logic q);
    quad_mode <= q;
    push({8'h03, b, 24'h0}, 7);
    fork
      go(7);
      begin
        repeat (300) @(posedge clk);
        hold_req <= 1'b1;
        repeat (80) @(posedge clk);
        chk(paused, !q);
        chk(hbusy, 1'b1);
        hold_req <= 1'b0;
      end
    join
    chk(rxq.size(), 7);
    for (int k = 0; k < 3; k++) chk(rxq[4 + k], ex(b, k));
  endtask

  task bb(input logic [47:0] v, input int n);
    lnk2.cs_n <= 1'b0;
    repeat (10) @(posedge clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      lnk2.sclk <= 1'b0;
      lnk2.mosi <= v[i];
      repeat (10) @(posedge clk);
      lnk2.sclk <= 1'b1;
      repeat (10) @(posedge clk);
    end
    lnk2.sclk <= 1'b0;
    repeat (10) @(posedge clk);
    lnk2.cs_n <= 1'b1;
    lnk2.mosi <= ~lnk2.mosi;
    repeat (20) @(posedge clk);
  endtask

  initial
  begin
    rst_n = 0; cpol = 0; tx_valid = 0; tx_data = 0; start = 0; frame_len = 0;
    auto_write_enable_cmd = 0; hold_req = 0; quad_mode = 0; dev_busy = 0; rd_data = 0;
    lnk2.cs_n = 1; lnk2.sclk = 0; lnk2.mosi = 0; lnk2.hold_n = 1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    fr({8'h20, 24'h0ff000}, 4);
    chk(nr, 1);
    chk(nv, 0);
    auto_write_enable_cmd <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      a = adr[i];
      m = a & sfb_pkg::ARRAY_LAST;
      fr({ops[i], a}, 4);
      chk(nv, i + 1);
      chk(c, {ops[i], m, m[19:16], m[19:15], m[19:12]});
      chk(write_enable_latch, 0);
    end
    auto_write_enable_cmd <= 1'b0;
    fr(16'h0500, 2);
    chk(rxq[1], 8'h00);
    fr(8'h06, 1);
    chk(write_enable_latch, 1);
    dev_busy <= 1'b1;
    fr(16'h0500, 2);
    chk(rxq[1], 8'h03);
    fr({8'h20, 24'h0}, 4);
    chk(nr, 2);
    fr({8'h03, 32'h0}, 5);
    chk(rxq[4], 8'hff);
    chk(nv, 4);
    dev_busy <= 1'b0;
    push({8'h03, 24'h0ffffc, 96'h0}, 16);
    repeat (3) @(posedge clk);
    chk(tx_ready, 0);
    go(16);
    for (int k = 0; k < 12; k++) chk(rxq[4 + k], ex(24'h0ffffc, k));
    rdp(24'h0abcde, 1'b0);
    cpol <= 1'b1;
    rdp(24'h012345, 1'b1);
    bb(16'hff06, 16);
    chk(wel2, 0);
    bb({8'h03, 24'h0, 3'h5}, 35);
    bb(8'h06, 8);
    chk(wel2, 1);
    bb({8'h20, 24'h0, 1'b0}, 33);
    chk(nr2, 1);
    chk(nv2, 0);
    results();
  end
endmodule
`default_nettype wire
